// File: sdm_pkg.sv
package sdm_pkg;
   // frame layout
   localparam int SDM_FRAME_BITS = 16;
   localparam int SDM_CNT_W = 5;
   localparam int SDM_CH_N = 4;
   localparam int SDM_MEAS_W = 7;
   localparam int SDM_BIT_MODE_HI = 15;
   localparam int SDM_BIT_MODE_LO = 14;
   localparam int SDM_BIT_PAR = 13;
   localparam int SDM_BIT_CLR = 12;
   localparam int SDM_BIT_MSEL_HI = 11;
   localparam int SDM_BIT_MSEL_LO = 10;
   localparam int SDM_BIT_D9 = 9;
   localparam int SDM_BIT_RSEL = 8;
   localparam int SDM_BIT_CH_LO = 7;
   localparam int SDM_BIT_ZERO_HI = 7;
   localparam int SDM_BIT_ZERO_LO = 4;
   localparam logic [1:0] SDM_MODE_BITS = 2'h3;
   localparam logic [1:0] SDM_MSEL_MODE1 = 2'h0;
   localparam logic [1:0] SDM_MSEL_MODE2 = 2'h1;
   localparam logic [2:0] SDM_CH_MAX = 3'h3;
   localparam logic [15:0] SDM_ERR_WORD = 16'hD000;
   localparam logic [SDM_MEAS_W-1:0] SDM_MEAS_FULL = 7'h7F;

   // timing: measurement step and activation window
   localparam int SDM_CLK_MHZ = 250;
   localparam int SDM_MEAS_STEP_NS = 25000;
   localparam int SDM_MEAS_STEP_CYC = SDM_MEAS_STEP_NS * SDM_CLK_MHZ / 1000;
   localparam int SDM_DEPLOY_NS = 500000;
   localparam int SDM_DEPLOY_CYC = SDM_DEPLOY_NS * SDM_CLK_MHZ / 1000;
   localparam int SDM_TMR_W = 24;

   // register map (byte addresses, word index on a 4-bit address)
   localparam logic [3:0] SDM_REG_STATUS = 4'h0;
   localparam logic [3:0] SDM_REG_MASK = 4'h4;
   localparam logic [3:0] SDM_REG_FLAGS = 4'h8;
   localparam logic [3:0] SDM_REG_CTRL = 4'hC;
   localparam int SDM_EVT_N = 4;
   localparam int SDM_EVT_FRAME = 0;
   localparam int SDM_EVT_PARITY = 1;
   localparam int SDM_EVT_LENGTH = 2;
   localparam int SDM_EVT_DONE = 3;
   localparam int SDM_FLAGS_DONE_LO = 4;

   typedef enum logic [1:0] {
      SDM_RESP_MODE1,
      SDM_RESP_MODE2
   } sdm_resp_t;
endpackage

// File: sdm_sync.sv
`timescale 1ns/1ps
module sdm_sync (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // asynchronous level in, filtered level out
   input wire logic async_i,
   output logic sync_o
);
   logic ff1_reg;
   logic ff2_reg;
   logic ff3_reg;

   // three stages; the output only moves once stages two and three agree
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ff1_reg <= 1'b0;
         ff2_reg <= 1'b0;
         ff3_reg <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         ff1_reg <= async_i;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         if (ff2_reg == ff3_reg) begin
            sync_o <= ff3_reg;
         end
      end
   end
endmodule

// File: sdm_monitor.sv
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - monitor frames carry 11 in D15:D14; mode 1 command has D12..D9 zero.
// - D13 is odd parity over all 16 bits, generated and checked.
// - mode 1 D8 picks done or active flags for D3..D0; echoed in D8.
// - mode 1 command D3..D0 set to one clears that channel's done flag.
// - done flag sets when the activation period of a fired channel expires.
// - done flag holds until the host writes its clear bit; nothing else clears.
// - active flag sets on a valid arm and fire, regardless of fire enable.
// - active flag clears on timeout, after one to two activation windows.
// - reported deployment status is sampled at the select falling edge.
// - (active,done) pair: 00 idle, 01 done, 10 in progress, 11 terminated.
// - while done is set, fire requests for that channel are ignored.
// - mode 2 response: 11, parity, 0, 01, channel, measurement data.
// - mode 2 with D12 set clears the selected channel's measurement time.
// - mode 2 channel code above 3 answers with the fixed error word.
// - measurement counts in 25 us steps, seven bits, saturating at full scale.
module sdm_monitor #(
   parameter int DEPLOY_CYC = sdm_pkg::SDM_DEPLOY_CYC,
   parameter int MEAS_STEP_CYC = sdm_pkg::SDM_MEAS_STEP_CYC
) (
   // system
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // spi link, device side
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   // squib channel events
   input wire logic [sdm_pkg::SDM_CH_N-1:0] arm_fire_i,
   input wire logic [sdm_pkg::SDM_CH_N-1:0] fire_enable_gate_i,
   input wire logic [sdm_pkg::SDM_CH_N-1:0] low_side_driver_fault_i,
   input wire logic [sdm_pkg::SDM_CH_N-1:0] current_limit_i,
   output logic [sdm_pkg::SDM_CH_N-1:0] driver_on_o,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt
   output logic irq_o
);
   import sdm_pkg::*;

   logic sclk_s, cs_n_s, mosi_s;
   logic sclk_d_reg, cs_n_d_reg;
   logic [SDM_FRAME_BITS-1:0] rx_reg, tx_reg;
   logic [SDM_CNT_W-1:0] bit_cnt_reg;
   logic report_select_reg;
   logic [2:0] meas_sel_reg;
   sdm_resp_t resp_reg;
   logic [SDM_CH_N-1:0] deploy_active_flag, deploy_done_flag;
   logic [SDM_CH_N-1:0] clr_done, clr_meas, done_set;
   logic [SDM_MEAS_W-1:0] meas_val [SDM_CH_N];
   logic [SDM_EVT_N-1:0] status_reg, mask_reg, evt;
   logic spi_enable_reg, ack_reg;
   logic cs_fall, cs_rise, sclk_rise, sclk_fall;
   logic [SDM_FRAME_BITS-1:0] resp_word, cmd_word;
   logic cmd_par_ok, cmd_len_ok, cmd_mode1, cmd_mode2, cmd_ch_ok;

   // pins arrive from the host's clock domain
   sdm_sync u_sync_sclk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .async_i(spi_sclk_i), .sync_o(sclk_s));
   sdm_sync u_sync_cs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .async_i(spi_cs_n_i), .sync_o(cs_n_s));
   sdm_sync u_sync_mosi (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .async_i(spi_mosi_i), .sync_o(mosi_s));

   // edge detection on the filtered levels; select idles high
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         sclk_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_n_d_reg <= cs_n_s;
      end
   end

   // u_sync_cs resets low, so gate select edges until it has settled high once
   assign cs_fall = cs_n_d_reg & ~cs_n_s & spi_enable_reg;
   assign cs_rise = ~cs_n_d_reg & cs_n_s;
   assign sclk_rise = ~sclk_d_reg & sclk_s & ~cs_n_s;
   assign sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s;

   // odd parity: put the bit in D13 so that the whole word has odd weight
   function automatic logic [SDM_FRAME_BITS-1:0] with_par(input logic [SDM_FRAME_BITS-1:0] w);
      logic [SDM_FRAME_BITS-1:0] r;
      r = w;
      r[SDM_BIT_PAR] = 1'b0;
      r[SDM_BIT_PAR] = ~(^r);
      return r;
   endfunction

   // response built from live flags at the moment select falls
   always_comb begin
      resp_word = '0;
      resp_word[SDM_BIT_MODE_HI:SDM_BIT_MODE_LO] = SDM_MODE_BITS;
      if (resp_reg == SDM_RESP_MODE2) begin
         if (meas_sel_reg > SDM_CH_MAX) begin
            resp_word = SDM_ERR_WORD;
         end else begin
            resp_word[SDM_BIT_MSEL_HI:SDM_BIT_MSEL_LO] = SDM_MSEL_MODE2;
            resp_word[SDM_BIT_D9:SDM_BIT_CH_LO] = meas_sel_reg;
            resp_word[SDM_MEAS_W-1:0] = meas_val[meas_sel_reg[1:0]];
            resp_word = with_par(resp_word);
         end
      end else begin
         // D12..D9 and D7..D4 stay zero in mode 1
         resp_word[SDM_BIT_RSEL] = report_select_reg;
         resp_word[SDM_CH_N-1:0] = report_select_reg ? deploy_active_flag
                                                      : deploy_done_flag;
         resp_word = with_par(resp_word);
      end
   end

   // shifter: capture on sclk rise, launch on sclk fall, msb first
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_reg <= '0;
         tx_reg <= '0;
         bit_cnt_reg <= '0;
      end else if (cs_fall) begin
         tx_reg <= resp_word;
         bit_cnt_reg <= '0;
      end else begin
         if (sclk_rise) begin
            rx_reg <= {rx_reg[SDM_FRAME_BITS-2:0], mosi_s};
            if (bit_cnt_reg != SDM_CNT_W'(SDM_FRAME_BITS + 1)) begin
               bit_cnt_reg <= bit_cnt_reg + SDM_CNT_W'(1);
            end
         end
         if (sclk_fall) begin
            tx_reg <= {tx_reg[SDM_FRAME_BITS-2:0], 1'b0};
         end
      end
   end

   // miso driven only while the frame is open
   assign spi_miso_o = tx_reg[SDM_FRAME_BITS-1];
   assign spi_miso_oe_n_o = cs_n_s;

   // command decode at frame end
   assign cmd_word = rx_reg;
   assign cmd_par_ok = ^cmd_word;
   assign cmd_len_ok = (bit_cnt_reg == SDM_CNT_W'(SDM_FRAME_BITS));
   assign cmd_mode1 = (cmd_word[SDM_BIT_MODE_HI:SDM_BIT_MODE_LO] == SDM_MODE_BITS)
      && !cmd_word[SDM_BIT_CLR] && !cmd_word[SDM_BIT_D9]
      && (cmd_word[SDM_BIT_MSEL_HI:SDM_BIT_MSEL_LO] == SDM_MSEL_MODE1);
   assign cmd_mode2 = (cmd_word[SDM_BIT_MODE_HI:SDM_BIT_MODE_LO] == SDM_MODE_BITS)
      && (cmd_word[SDM_BIT_MSEL_HI:SDM_BIT_MSEL_LO] == SDM_MSEL_MODE2);
   assign cmd_ch_ok = (cmd_word[SDM_BIT_D9:SDM_BIT_CH_LO] <= SDM_CH_MAX);

   // clear pulses; a damaged frame clears nothing
   always_comb begin
      clr_done = '0;
      clr_meas = '0;
      if (cs_rise && cmd_len_ok && cmd_par_ok && spi_enable_reg) begin
         if (cmd_mode1) begin
            clr_done = cmd_word[SDM_CH_N-1:0];
         end else if (cmd_mode2 && cmd_word[SDM_BIT_CLR] && cmd_ch_ok) begin
            clr_meas[cmd_word[SDM_BIT_CH_LO+1:SDM_BIT_CH_LO]] = 1'b1;
         end
      end
   end

   // stored settings and the kind of the next response
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         report_select_reg <= 1'b0;
         meas_sel_reg <= '0;
         resp_reg <= SDM_RESP_MODE1;
      end else if (cs_rise && cmd_len_ok && cmd_par_ok && spi_enable_reg) begin
         if (cmd_mode1) begin
            report_select_reg <= cmd_word[SDM_BIT_RSEL];
            resp_reg <= SDM_RESP_MODE1;
         end else if (cmd_mode2) begin
            meas_sel_reg <= cmd_word[SDM_BIT_D9:SDM_BIT_CH_LO];
            resp_reg <= SDM_RESP_MODE2;
         end
      end
   end

   // per-channel deployment sequencer and measurement timer
   for (genvar ch = 0; ch < SDM_CH_N; ch++) begin : g_ch
      typedef enum logic [1:0] {SDM_CH_IDLE, SDM_CH_WAIT_EN, SDM_CH_FIRE} sdm_ch_t;
      sdm_ch_t st_reg;
      logic [SDM_TMR_W-1:0] tmr_reg;
      logic [SDM_TMR_W-1:0] step_reg;
      logic [SDM_MEAS_W-1:0] meas_reg;
      logic expired;

      assign expired = (tmr_reg == SDM_TMR_W'(DEPLOY_CYC - 1));

      // waiting for fire enable takes one window, firing another: 1x to 2x
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            st_reg <= SDM_CH_IDLE;
            tmr_reg <= '0;
         end else begin
            case (st_reg)
               SDM_CH_IDLE: begin
                  tmr_reg <= '0;
                  if (arm_fire_i[ch] && !deploy_done_flag[ch]) begin
                     st_reg <= fire_enable_gate_i[ch] ? SDM_CH_FIRE : SDM_CH_WAIT_EN;
                  end
               end
               SDM_CH_WAIT_EN: begin
                  if (fire_enable_gate_i[ch]) begin
                     st_reg <= SDM_CH_FIRE;
                     tmr_reg <= '0;
                  end else if (expired) begin
                     st_reg <= SDM_CH_IDLE;
                  end else begin
                     tmr_reg <= tmr_reg + SDM_TMR_W'(1);
                  end
               end
               SDM_CH_FIRE: begin
                  if (expired) begin
                     st_reg <= SDM_CH_IDLE;
                  end else begin
                     tmr_reg <= tmr_reg + SDM_TMR_W'(1);
                  end
               end
               default: st_reg <= SDM_CH_IDLE;
            endcase
         end
      end

      assign deploy_active_flag[ch] = (st_reg != SDM_CH_IDLE);
      assign driver_on_o[ch] = (st_reg == SDM_CH_FIRE) && !deploy_done_flag[ch];
      // low side shutdown ends firing early and leaves the 11 pattern
      assign done_set[ch] = (st_reg == SDM_CH_FIRE)
         && (expired || low_side_driver_fault_i[ch]);

      // sticky done flag, set wins over a clear in the same cycle
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            deploy_done_flag[ch] <= 1'b0;
         end else if (done_set[ch]) begin
            deploy_done_flag[ch] <= 1'b1;
         end else if (clr_done[ch]) begin
            deploy_done_flag[ch] <= 1'b0;
         end
      end

      // time spent in current limit while driving, saturating at full scale
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            step_reg <= '0;
            meas_reg <= '0;
         end else if (clr_meas[ch]) begin
            step_reg <= '0;
            meas_reg <= '0;
         end else if (driver_on_o[ch] && current_limit_i[ch]) begin
            if (step_reg == SDM_TMR_W'(MEAS_STEP_CYC - 1)) begin
               step_reg <= '0;
               if (meas_reg != SDM_MEAS_FULL) begin
                  meas_reg <= meas_reg + SDM_MEAS_W'(1);
               end
            end else begin
               step_reg <= step_reg + SDM_TMR_W'(1);
            end
         end
      end
      assign meas_val[ch] = meas_reg;
   end

   // the link opens only after select has been seen high once
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         spi_enable_reg <= 1'b0;
      end else if (cs_n_s && cs_n_d_reg) begin
         spi_enable_reg <= 1'b1;
      end
   end

   // interrupt events, one cycle each; done stays high as long as a low side fault holds while firing
   always_comb begin
      evt = '0;
      evt[SDM_EVT_FRAME] = cs_rise && spi_enable_reg && cmd_len_ok && cmd_par_ok;
      evt[SDM_EVT_PARITY] = cs_rise && spi_enable_reg && cmd_len_ok && !cmd_par_ok;
      evt[SDM_EVT_LENGTH] = cs_rise && spi_enable_reg && !cmd_len_ok;
      evt[SDM_EVT_DONE] = |done_set;
   end

   // bus handshake: one wait cycle, then the answer
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
      end
   end

   // status bits: write one to clear, a new event wins
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         status_reg <= '0;
      end else if (avs_write && ack_reg && avs_address == SDM_REG_STATUS) begin
         status_reg <= (status_reg & ~avs_writedata[SDM_EVT_N-1:0]) | evt;
      end else begin
         status_reg <= status_reg | evt;
      end
   end

   // mask register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mask_reg <= '0;
      end else if (avs_write && ack_reg && avs_address == SDM_REG_MASK) begin
         mask_reg <= avs_writedata[SDM_EVT_N-1:0];
      end
   end

   // read data latched in the wait cycle, stands while waitrequest is low
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         avs_readdata <= '0;
      end else if (avs_read && !ack_reg) begin
         if (avs_address == SDM_REG_STATUS) begin
            avs_readdata <= 32'(status_reg);
         end else if (avs_address == SDM_REG_MASK) begin
            avs_readdata <= 32'(mask_reg);
         end else if (avs_address == SDM_REG_FLAGS) begin
            avs_readdata <= 32'({deploy_done_flag, deploy_active_flag});
         end else if (avs_address == SDM_REG_CTRL) begin
            avs_readdata <= 32'({meas_sel_reg, report_select_reg});
         end else begin
            avs_readdata <= '0;
         end
      end
   end

   assign irq_o = |(status_reg & mask_reg);
endmodule

// File: sdm_props.sv
`timescale 1ns/1ps
module sdm_props #(
   parameter int DEPLOY_CYC = 125000
) (
   // system
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // spi pins
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_miso_o,
   input wire logic spi_miso_oe_n_o,
   // channel drive
   input wire logic [sdm_pkg::SDM_CH_N-1:0] driver_on_o,
   // avalon-mm
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   import sdm_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   int on_cnt;
   // length of the current drive burst on channel 0; a counter, since it is far over 8
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i || !driver_on_o[0]) begin
         on_cnt <= 0;
      end else begin
         on_cnt <= on_cnt + 1;
      end
   end
   // bus request in its wait cycle; frame opened with the link clock still low
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_open;
      $fell(spi_cs_n_i) ##1 (!spi_cs_n_i && !spi_sclk_i) [*8];
   endsequence
   a_bus_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("bus request answered without a wait cycle");
   a_bus_one_wait: assert property (s_req |=> !avs_waitrequest)
      else $error("bus answer not one cycle after the request");
   a_unmapped_zero: assert property ((s_req and (avs_read && avs_address[1:0] != 2'h0))
      |=> avs_readdata == 32'h0)
      else $error("unmapped read returned data");
   a_frame_lead: assert property (s_open |-> spi_miso_o)
      else $error("first response bit is not one");
   a_miso_steady: assert property (spi_sclk_i [*6] |-> $stable(spi_miso_o))
      else $error("response bit moved while link clock high");
   a_oe_drive: assert property (!spi_cs_n_i [*6] |-> !spi_miso_oe_n_o)
      else $error("response line not driven inside frame");
   a_oe_release: assert property (spi_cs_n_i [*8] |-> spi_miso_oe_n_o)
      else $error("response line driven outside frame");
   a_drive_limit: assert property (on_cnt <= DEPLOY_CYC)
      else $error("channel driven past the activation period");
endmodule

// File: sdm_host.sv
`timescale 1ns/1ps
module sdm_host (
   // spi pins toward the device
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   // mode 0 master: link clock idles low and stands still between frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one frame, msb first; a count other than 16 only to provoke a refusal
   task automatic frame(input logic [15:0] c, input int n, output logic [15:0] r);
      r = 16'h0;
      #1.3 cs_n_o = 1'b0;
      #60;
      for (int i = 0; i < n; i++) begin
         mosi_o = c[15-i];
         #40 sclk_o = 1'b1;
         r = {r[14:0], miso_i};
         #40 sclk_o = 1'b0;
      end
      #20 cs_n_o = 1'b1;
      mosi_o = ~mosi_o; // released line must not keep a stale value
      #60;
   endtask
endmodule

// File: sdm_monitor_tb.sv
`timescale 1ns/1ps
module sdm_monitor_tb;
   import sdm_pkg::*;
   localparam int DC = 2000;
   localparam int MS = 4;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sclk, cs_n, mosi, miso, oe_n, irq;
   logic [3:0] af = 4'h0, fire_enable_gate = 4'hB, low_side_driver = 4'h0, cl = 4'h0, drv;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [15:0] r;
   int error_cnt = 0, tests_run = 0;
   // 250 MHz system clock
   always #2 clk_sys_i = ~clk_sys_i;
   sdm_monitor #(.DEPLOY_CYC(DC), .MEAS_STEP_CYC(MS)) u_sdm_monitor (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .arm_fire_i(af),
      .fire_enable_gate_i(fire_enable_gate), .low_side_driver_fault_i(low_side_driver), .current_limit_i(cl),
      .driver_on_o(drv), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq_o(irq));
   sdm_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
   // odd parity over the whole word sits in bit 13
   function automatic logic [15:0] par(input logic [15:0] w);
      w[13] = 1'b0;
      w[13] = ~^w;
      return w;
   endfunction
   function automatic logic [15:0] m1(input logic rs, input logic [3:0] f);
      return par({7'h60, rs, 4'h0, f});
   endfunction
   function automatic logic [15:0] m2(input logic c, input logic [2:0] ch, input logic [6:0] m);
      return par({3'h6, c, 2'h1, ch, m});
   endfunction
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // one avalon access; waitrequest and read data are taken at the same rising edge
   // only the watchdog ends a wait that never sees waitrequest low
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys_i);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys_i);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic sp(input logic [15:0] c, input logic [15:0] e);
      u_host.frame(c, 16, r);
      chk("response", r, e);
   endtask
   task automatic fire(input int ch);
      @(posedge clk_sys_i);
      af <= 4'h1 << ch;
      repeat (2) @(posedge clk_sys_i);
      af <= 4'h0;
   endtask
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         bus(4'(i * 4), 1'b0, 32'h0);
         chk("reg_reset", q, 32'h0);
      end
      bus(4'h2, 1'b0, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(SDM_REG_CTRL, 1'b1, 32'hF);
      bus(SDM_REG_CTRL, 1'b0, 32'h0);
      chk("ctrl_ro", q, 32'h0);
      bus(SDM_REG_MASK, 1'b1, 32'hF);
      bus(SDM_REG_MASK, 1'b0, 32'h0);
      chk("mask_rw", q, 32'hF);
      bus(SDM_REG_MASK, 1'b1, 32'h0);
   endtask
   task automatic t_deploy;
      sp(m1(1'b1, 4'h0), m1(1'b0, 4'h0));
      fire(0);
      sp(m1(1'b1, 4'h0), m1(1'b1, 4'h1));
      fire(2);
      sp(m1(1'b0, 4'h0), m1(1'b1, 4'h5));
      chk("driver_on", drv, 4'h1);
      repeat (2 * DC + 50) @(posedge clk_sys_i);
      sp(m1(1'b1, 4'h0), m1(1'b0, 4'h1));
      fire(0);
      sp(m1(1'b0, 4'hE), m1(1'b1, 4'h0));
      chk("driver_on", drv, 4'h0);
      sp(m1(1'b0, 4'h1), m1(1'b0, 4'h1));
      sp(m1(1'b0, 4'h0), m1(1'b0, 4'h0));
   endtask
   // a low side fault ends firing early but keeps the active flag
   task automatic t_fault;
      fire(1);
      low_side_driver <= 4'h2;
      repeat (4) @(posedge clk_sys_i);
      low_side_driver <= 4'h0;
      sp(m1(1'b1, 4'h0), m1(1'b0, 4'h2));
      sp(m1(1'b1, 4'h2), m1(1'b1, 4'h2));
      repeat (2 * DC + 50) @(posedge clk_sys_i);
      sp(m1(1'b1, 4'h0), m1(1'b1, 4'h0));
   endtask
   task automatic t_irq;
      bus(SDM_REG_MASK, 1'b1, 32'h1);
      repeat (2) @(posedge clk_sys_i);
      chk("irq_raised", irq, 1'b1);
      bus(SDM_REG_STATUS, 1'b1, 32'h1);
      repeat (2) @(posedge clk_sys_i);
      chk("irq_cleared", irq, 1'b0);
      bus(SDM_REG_STATUS, 1'b0, 32'h0);
      chk("status_w1c", q & 32'h1, 32'h0);
      bus(SDM_REG_MASK, 1'b1, 32'h0);
   endtask
   // channel 3 must be driving for its current limit time to count
   task automatic t_meas;
      fire(3);
      cl <= 4'h8;
      repeat (140 * MS) @(posedge clk_sys_i);
      cl <= 4'h0;
      sp(m2(1'b0, 3'h3, 7'h0), m1(1'b1, 4'h8));
      chk("irq_masked", irq, 1'b0);
      sp(m2(1'b0, 3'h0, 7'h0), m2(1'b0, 3'h3, 7'h7F));
      sp(m2(1'b1, 3'h3, 7'h0), m2(1'b0, 3'h0, 7'h00));
      sp(m2(1'b0, 3'h5, 7'h0), m2(1'b0, 3'h3, 7'h00));
      sp(m2(1'b0, 3'h3, 7'h0) ^ 16'h2000, 16'hD000);
      sp(m1(1'b0, 4'h0), 16'hD000);
      u_host.frame(m1(1'b0, 4'h0), 15, r);
      bus(SDM_REG_STATUS, 1'b0, 32'h0);
      chk("status_errors", q & 32'h6, 32'h6);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // reset, then the scenarios in order
   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      t_regs;
      t_deploy;
      t_fault;
      t_irq;
      t_meas;
      close_out;
   end
   // watchdog well past the expected run of roughly 15k cycles
   initial begin
      #300000;
      error_cnt++;
      close_out;
   end
endmodule
bind sdm_monitor sdm_props #(.DEPLOY_CYC(DEPLOY_CYC)) u_sdm_props (
   .clk_sys_i, .rst_n_i, .spi_sclk_i, .spi_cs_n_i, .spi_miso_o, .spi_miso_oe_n_o,
   .driver_on_o, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);
